/* File: rtl/lsi_channel.v */
`timescale 1ns/1ps
// Functional notes
// - live alarm-indication bit 1 of first status register follows detector
// - unmasked alarm-indication event: rising edge, or any change when edge-select set
// - live signal-loss bit 0 follows the receive line pair detector
// - unmasked signal-loss event: rising edge, or any change when edge-select set
// - remote loopback state at bit 5 of second status register; rest zero
// - each channel's registers repeat at offsets spaced 0x40
// - reading first event register clears all its bits except any whose event arrives in the same cycle
// - first event register holds seven latched flags, bit 7 reserved zero
// - reading second event register clears it and drops its request
// - waveform amplitude overflow sets bit 7 of second event register
// - jitter buffer overflow sets bit 6, underflow sets bit 5
// - pattern error, excess zeros, code violation, second timer, counter overflow flags
// - low byte of the error counter reads back, reset zero
// - transmit clock loss live after more than 70 cycles without toggle
// - edge-select 0 means rising transition, 1 means either transition
`include "lsi_regs.vh"
module lsi_channel #(
    parameter [1:0] CHAN_ID = 2'd0
)(
    input  wire        clk,
    input  wire        rst_b,
    input  wire        rd_en,
    input  wire [7:0]  rd_addr,
    output reg  [7:0]  rd_data_q,
    output reg         rd_hit_q,
    input  wire        signal_loss_det,
    input  wire        alarm_ind_det,
    input  wire        driver_fault_det,
    input  wire        pattern_sync_det,
    input  wire        activate_code_det,
    input  wire        deactivate_code_det,
    input  wire        remote_loop_det,
    input  wire        tx_clock_in,
    input  wire [6:0]  live_mask,
    input  wire [6:0]  live_edge_sel,
    input  wire [7:0]  event_pulse_b,
    input  wire [7:0]  mask_b,
    input  wire [7:0]  error_count_low_byte,
    output reg         irq_q
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // detector outputs and the tx clock pin come from other domains
    reg  [7:0]  sync1_q;
    reg  [7:0]  sync2_q;
    wire [7:0]  raw_in = {tx_clock_in, remote_loop_det, activate_code_det, deactivate_code_det,
                          pattern_sync_det, driver_fault_det, alarm_ind_det, signal_loss_det};
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end
    // ----------------------------------------
    // transmit clock watchdog
    // ----------------------------------------
    reg         txc_prev_q;
    reg  [6:0]  txc_cnt_q;
    reg         tx_clock_loss_live_q;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txc_prev_q           <= 1'b0;
            txc_cnt_q            <= 7'd0;
            tx_clock_loss_live_q <= 1'b0;
        end
        else
        begin
            txc_prev_q <= sync2_q[7];
            if (sync2_q[7] != txc_prev_q)
            begin
                txc_cnt_q            <= 7'd0;
                tx_clock_loss_live_q <= 1'b0;
            end
            else if (txc_cnt_q < `LSI_TXCLK_LOSS_CYC)
                txc_cnt_q <= txc_cnt_q + 7'd1;
            else
                tx_clock_loss_live_q <= 1'b1;
        end
    end
    // ----------------------------------------
    // live status and edge events
    // ----------------------------------------
    // live_a bit 7 reserved; bit 3 replaced by the watchdog
    wire [6:0]  live_a = {sync2_q[5], sync2_q[4], sync2_q[3], tx_clock_loss_live_q,
                          sync2_q[2], sync2_q[1], sync2_q[0]};
    wire [7:0]  live_b = {2'b00, sync2_q[6], 5'b00000};
    reg  [6:0]  live_prev_q;
    reg  [6:0]  event_a;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_edge
            always @*
            begin
                // mask 0 enables the event source
                event_a[gi] = ~live_mask[gi] & (live_edge_sel[gi] ? (live_a[gi] ^ live_prev_q[gi])
                               : (live_a[gi] & ~live_prev_q[gi]));
            end
        end
    endgenerate
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire [7:0]  base = `LSI_CHAN_STRIDE * {6'd0, CHAN_ID};
    wire [7:0]  local_addr = rd_addr - base;
    wire        in_chan = (rd_addr[7:6] == CHAN_ID);
    wire        rd_a = rd_en & in_chan & (local_addr == `LSI_OFF_FLAGS_A);
    wire        rd_b = rd_en & in_chan & (local_addr == `LSI_OFF_FLAGS_B);
    // ----------------------------------------
    // latched event flags
    // ----------------------------------------
    reg  [6:0]  flags_a_q;
    reg  [7:0]  flags_b_q;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            live_prev_q <= 7'd0;
            flags_a_q   <= 7'd0;
            flags_b_q   <= `LSI_RST_BYTE;
        end
        else
        begin
            live_prev_q <= live_a;
            // set wins over the clearing read
            flags_a_q <= (rd_a ? 7'd0 : flags_a_q) | event_a;
            flags_b_q <= (rd_b ? 8'h00 : flags_b_q) | event_pulse_b;
        end
    end
    // ----------------------------------------
    // read data and request
    // ----------------------------------------
    reg  [7:0]  rd_mux;
    always @*
    begin
        rd_mux = 8'h00;
        case (local_addr)
            `LSI_OFF_LIVE_A:  rd_mux = {1'b0, live_a};
            `LSI_OFF_LIVE_B:  rd_mux = live_b;
            `LSI_OFF_FLAGS_A: rd_mux = {1'b0, flags_a_q};
            `LSI_OFF_FLAGS_B: rd_mux = flags_b_q;
            `LSI_OFF_CNT_LOW: rd_mux = error_count_low_byte;
            default:          rd_mux = 8'h00;
        endcase
    end
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_q <= `LSI_RST_BYTE;
            rd_hit_q  <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            rd_hit_q  <= rd_en & in_chan;
            rd_data_q <= (rd_en & in_chan) ? rd_mux : 8'h00;
            // flags_a set only when unmasked, so all of it counts
            irq_q <= (|flags_a_q) | (|(flags_b_q & ~mask_b));
        end
    end
endmodule

/* File: rtl/lsi_regs.vh */
`ifndef LSI_REGS_VH
`define LSI_REGS_VH
// ----------------------------------------
// register offsets within one channel
// ----------------------------------------
`define LSI_OFF_LIVE_A      8'h14
`define LSI_OFF_LIVE_B      8'h15
`define LSI_OFF_FLAGS_A     8'h16
`define LSI_OFF_FLAGS_B     8'h17
`define LSI_OFF_CNT_LOW     8'h18
`define LSI_CHAN_STRIDE     8'h40
// ----------------------------------------
// field positions
// ----------------------------------------
`define LSI_BIT_SIG_LOSS    0
`define LSI_BIT_ALARM_IND   1
`define LSI_BIT_DRV_FAULT   2
`define LSI_BIT_TX_CLK_LOSS 3
`define LSI_BIT_PAT_SYNC    4
`define LSI_BIT_DEACT_CODE  5
`define LSI_BIT_ACT_CODE    6
`define LSI_BIT_REMOTE_LOOP 5
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define LSI_RST_BYTE        8'h00
`define LSI_TXCLK_LOSS_CYC  7'd70
`endif

/* File: sim/lsi_channel_assertions.sv */
`timescale 1ns/1ps
module lsi_chk #(parameter [1:0] CHAN_ID = 2'd0) (
    input wire       clk,
    input wire       rst_b,
    input wire       rd_en,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data_q,
    input wire       rd_hit_q,
    input wire       signal_loss_det,
    input wire       alarm_ind_det,
    input wire [7:0] event_pulse_b,
    input wire [7:0] mask_b,
    input wire [7:0] error_count_low_byte,
    input wire       irq_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire me = rd_en && rd_addr[7:6] == CHAN_ID;
    wire [5:0] o = rd_addr[5:0];
    AST_HIT: assert property (rd_en |=> rd_hit_q == $past(me)) else $error("hit");
    AST_MISS: assert property (rd_en && !me |=> rd_data_q == 8'h00) else $error("miss");
    AST_CNT: assert property (me && o == 6'h18 |=> rd_data_q == $past(error_count_low_byte)) else $error("cnt");
    AST_RSVD_B: assert property (me && o == 6'h15 |=> (rd_data_q & 8'hdf) == 8'h00) else $error("rsvd");
    AST_RSVD_A: assert property (me && o == 6'h16 |=> !rd_data_q[7]) else $error("bit7");
    AST_CLR_B: assert property (me && o == 6'h17 && event_pulse_b == 8'h00 ##1 event_pulse_b == 8'h00
        ##1 me && o == 6'h17 && event_pulse_b == 8'h00 |=> rd_data_q == 8'h00) else $error("clr");
    AST_SET_B: assert property (event_pulse_b != 8'h00 ##1 me && o == 6'h17
        |=> (rd_data_q & $past(event_pulse_b, 2)) == $past(event_pulse_b, 2)) else $error("lost");
    AST_IRQ: assert property (|(event_pulse_b & ~mask_b) |-> ##2 irq_q) else $error("irq");
    AST_LIVE: assert property ($stable({signal_loss_det, alarm_ind_det})[*4] ##0 me && o == 6'h14
        |=> rd_data_q[1:0] == $past({alarm_ind_det, signal_loss_det})) else $error("live");
    cover property (me && o == 6'h16 ##1 rd_data_q != 8'h00);
    cover property ($rose(irq_q));
    cover property ($fell(irq_q));
endmodule
bind lsi_channel lsi_chk #(.CHAN_ID(CHAN_ID)) lsi_chk_inst (.clk, .rst_b, .rd_en, .rd_addr, .rd_data_q,
    .rd_hit_q, .signal_loss_det, .alarm_ind_det, .event_pulse_b, .mask_b, .error_count_low_byte, .irq_q);

/* File: sim/lsi_host.sv */
`timescale 1ns/1ps
module lsi_host (
    input  wire       clk,
    input  wire [7:0] rd_data_q,
    input  wire       rd_hit_q,
    output reg        rd_en = 1'b0,
    output reg  [7:0] rd_addr = 8'h00
);
    // address inverted on release so a stale value never looks valid
    task rd(input [7:0] a, output [7:0] d, output h);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        #1;
        d = rd_data_q;
        h = rd_hit_q;
    endtask
endmodule

/* File: sim/test_line_status_interrupt_regs.sv */
`timescale 1ns/1ps
module test_line_status_interrupt_regs;
    reg        clk = 1'b0;
    reg        rst_b = 1'b0;
    reg        tx = 1'b0;
    reg        tx_run = 1'b1;
    reg  [6:0] dv = 7'h00;
    reg  [7:0] pulse = 8'h00;
    reg  [7:0] mask_b = 8'hfe;
    reg  [7:0] cnt = 8'h00;
    wire       rd_en, rd_hit_q, irq_q;
    wire [7:0] rd_addr, rd_data_q, d;
    int        n_errors = 0;
    int        checked = 0;
    reg  [7:0] q;
    reg        h;
    always #10 clk = ~clk;
    always @(posedge clk) if (tx_run) tx <= ~tx;
    lsi_channel #(.CHAN_ID(2'd1)) lsi_channel_inst (.clk, .rst_b, .rd_en, .rd_addr, .rd_data_q, .rd_hit_q,
        .signal_loss_det(dv[0]), .alarm_ind_det(dv[1]), .driver_fault_det(dv[2]), .pattern_sync_det(dv[4]),
        .activate_code_det(dv[6]), .deactivate_code_det(dv[5]), .remote_loop_det(dv[3]), .tx_clock_in(tx),
        .live_mask(7'h7c), .live_edge_sel(7'h02), .event_pulse_b(pulse), .mask_b, .error_count_low_byte(cnt), .irq_q);
    lsi_host lsi_host_inst (.clk, .rd_data_q, .rd_hit_q, .rd_en, .rd_addr);
    task chk(input string n, input [7:0] e, input [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task finish_test;
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task rd(input [7:0] a);
        lsi_host_inst.rd(a, q, h);
    endtask
    task t_map;
        @(posedge clk);
        cnt <= 8'h81;
        rd(8'h18);
        chk("foreign hit", 8'h00, {7'h0, h});
        rd(8'h58);
        chk("count low", 8'h81, q);
        chk("own hit", 8'h01, {7'h0, h});
    endtask
    task t_txloss;
        @(posedge clk);
        tx_run <= 1'b0;
        repeat (80) @(posedge clk);
        rd(8'h54);
        chk("tx clock loss", 8'h08, q);
        @(posedge clk);
        tx_run <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h54);
        chk("tx clock back", 8'h00, q);
    endtask
    task t_live;
        @(posedge clk);
        dv <= 7'h0b;
        repeat (5) @(posedge clk);
        rd(8'h54);
        chk("live_a", 8'h03, q);
        rd(8'h55);
        chk("live_b", 8'h20, q);
        rd(8'h56);
        chk("rise flags", 8'h03, q);
        @(posedge clk);
        dv <= 7'h00;
        repeat (5) @(posedge clk);
        rd(8'h56);
        chk("fall flags", 8'h02, q);
        rd(8'h56);
        chk("flags_a cleared", 8'h00, q);
    endtask
    task t_flags_b(input [7:0] p, input [7:0] ei);
        @(posedge clk);
        pulse <= p;
        @(posedge clk);
        pulse <= 8'h00;
        repeat (2) @(posedge clk);
        #1 chk("irq set", ei, {7'h0, irq_q});
        rd(8'h57);
        chk("flags_b", p, q);
        rd(8'h57);
        chk("flags_b cleared", 8'h00, q);
        #1 chk("irq clear", 8'h00, {7'h0, irq_q});
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_map;
        t_live;
        t_txloss;
        t_flags_b(8'hff, 8'h01);
        t_flags_b(8'h01, 8'h01);
        t_flags_b(8'h02, 8'h00);
        finish_test;
    end
endmodule
